/* rtl/port_cfg.svh */
// offsets, field positions, reset values and timing counts of the port block
// assumes the includer knows nothing else; definitions only
`ifndef PORT_CFG_SVH
`define PORT_CFG_SVH

// word addresses on the avalon slave
`define ADDR_PORT 2'h0
`define ADDR_CFG 2'h1
`define ADDR_GPWR 2'h2

// port_status_control field positions
`define B_ATTACH 0
`define B_ACTIVE 1
`define B_SUSP 2
`define B_OVL 3
`define B_RESET 4
`define B_POWER 8
`define B_SLOW 9
`define B_ATT_CHG 16
`define B_EN_CHG 17
`define B_RES_DONE 18
`define B_OVL_CHG 19
`define B_RST_DONE 20

// global power command positions
`define B_ALL_OFF 0
`define B_ALL_ON 16

// configuration register positions and reset value
`define B_NO_PWR_SW 0
`define B_PER_PORT_SW 1
`define B_OVL_PER_PORT 2
`define B_IND_MASK 3
`define B_FIXED_DEV 4
`define CFG_RST 5'h00

// reset value of port_status_control: power on
`define PORT_RST 32'h0000_0100
// reset value of the packed port state: only port_powered set
`define PORT_STATE_RST 12'h020

// timing
`define CLK_MHZ 250
`define MS_CYCLES (`CLK_MHZ * 1000)
`define RESET_MS 10
`define RESUME_MS 20
`define RESYNC_MS 3
`define EOP_NS 1334
`define EOP_CYCLES ((`EOP_NS * `CLK_MHZ + 999) / 1000)

`endif

/* rtl/port_pkg.sv */
// types shared by the root hub port block
// assumes port_cfg.svh holds all numbers
package port_pkg;

	// sequencer states, gray along idle-resume-eop-resync
	typedef enum logic [2:0] {
		SEQ_IDLE = 3'h0,
		SEQ_RESUME = 3'h1,
		SEQ_EOP = 3'h3,
		SEQ_RESYNC = 3'h2,
		SEQ_RESET = 3'h6
	} seq_t;

	typedef struct packed {
		logic fixed_device_mask;
		logic individual_power_mask;
		logic ovl_per_port_sel;
		logic per_port_switch_sel;
		logic no_power_switch;
	} cfg_t;

	typedef struct packed {
		logic reset_done_flag;
		logic ovl_change_flag;
		logic resume_done_flag;
		logic enable_change_flag;
		logic attach_change_flag;
		logic slow_device_flag;
		logic port_powered;
		logic reset_active;
		logic overload_seen;
		logic suspended_state;
		logic link_active_state;
		logic attached_state;
	} port_t;

	typedef struct packed {
		logic read;
		logic write;
		logic [1:0] address;
		logic [3:0] byteenable;
		logic [31:0] writedata;
	} av_req_t;

endpackage

/* rtl/usb_root_hub_port.sv */
// status and control of one downstream root hub port
// assumes an avalon-mm master on sys_clk_in, async device pins synced here
//
// Summary of operation
// - resume-done sets only after resume pulse, low-speed eop and resync delay.
// - flags 18,17,16 clear by writing one, 18 also at the end of reset; zero leaves them.
// - resume-done clears whenever reset-done becomes set.
// - enable-change sets only on hardware clearing of enable, not writes.
// - attach-change sets on every connect or disconnect.
// - reset, enable or suspend command while detached sets attach-change instead.
// - fixed device port announces attach-change once after hub reset.
// - bit 9 reads one for low-speed device, zero for full-speed.
// - writing one to bit 9 turns port power off when per-port commands are selected.
// - overcurrent clears power when per-port reporting; power commands set and clear it.
// - switching mode and mask choose per-port or global power commands.
// - power off clears enabled, and except on a fixed device port also attached, suspended and reset-active states.
// - power bit resets to one and reads one without power switching.
// - writing one to bit 4 starts reset signalling while attached.
// - bit 3 follows overcurrent input when per-port reporting, else zero.
// - writing one to bit 3 starts resume only while suspended.
// - bit 2 write suspends if attached; resume, reset or wake clears it.
// - hardware clearing of enable by fault also sets enable-change.
// - enable sets at end of port reset or resume.
// - writing one to bit 1 enables the port while attached.
// - bit 0 shows attach, unwritable; writing one there disables the port.
// - fixed device port always reads attached.
// - reset-done sets at end of the 10 ms reset; writing one clears.
//
// The Avalon-MM interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/1ns
`include "port_cfg.svh"

module usb_root_hub_port #(
	parameter int MS_CYCLES = `MS_CYCLES
) (
	input wire logic sys_clk_in,
	input wire logic srst_in,
	input wire port_pkg::av_req_t av_in,
	output logic [31:0] av_readdata_out,
	output logic av_waitrequest_out,
	input wire logic dev_attach_in,
	input wire logic dev_slow_in,
	input wire logic overload_in,
	input wire logic bus_error_in,
	input wire logic controller_wake_state_in,
	output logic port_power_out,
	output logic port_active_out,
	output logic reset_drive_out,
	output logic resume_drive_out
);
	import port_pkg::*;

	localparam logic [17:0] MS_LAST = 18'(MS_CYCLES - 1);
	localparam logic [8:0] EOP_LAST = 9'(`EOP_CYCLES - 1);
	localparam logic [8:0] RESET_LAST = 9'(`RESET_MS - 1);
	localparam logic [8:0] RESUME_LAST = 9'(`RESUME_MS - 1);
	localparam logic [8:0] RESYNC_LAST = 9'(`RESYNC_MS - 1);

	// byte lane mask from avalon byte enables
	function automatic logic [31:0] lane_mask(input logic [3:0] be);
		logic [31:0] m;
		m = 32'h0000_0000;
		for (int i = 0; i < 4; i++) begin
			m[i*8 +: 8] = {8{be[i]}};
		end
		return m;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// pin synchronisers

	logic [2:0] pin_s1_q;
	logic [2:0] pin_s2_q;

	// first stage feeds only the second one
	always_ff @(posedge sys_clk_in) begin
		if (srst_in) begin
			pin_s1_q <= 3'h0;
			pin_s2_q <= 3'h0;
		end else begin
			pin_s1_q <= {overload_in, dev_slow_in, dev_attach_in};
			pin_s2_q <= pin_s1_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// avalon slave: fixed one wait cycle on every access

	logic wait_q, wait_d;
	logic [31:0] rdata_q, rdata_d;
	cfg_t cfg_q, cfg_d;
	port_t p_q, p_d;
	logic req;
	logic take;
	logic [31:0] wmask;
	logic [31:0] w1;
	logic [31:0] gp;

	assign req = av_in.read | av_in.write;
	assign take = req & ~wait_q;
	assign wmask = av_in.writedata & lane_mask(av_in.byteenable);
	// one-shot command strobes, valid only on the accepting edge
	assign w1 = (take && av_in.write && av_in.address == `ADDR_PORT) ? wmask : 32'h0000_0000;
	assign gp = (take && av_in.write && av_in.address == `ADDR_GPWR) ? wmask : 32'h0000_0000;

	// read mux; unmapped words read zero and ignore writes
	always_comb begin
		wait_d = ~(req & wait_q);
		rdata_d = rdata_q;
		cfg_d = cfg_q;
		if (req && wait_q && av_in.read) begin
			rdata_d = 32'h0000_0000;
			case (av_in.address)
				`ADDR_PORT: begin
					rdata_d[`B_RST_DONE] = p_q.reset_done_flag;
					rdata_d[`B_OVL_CHG] = p_q.ovl_change_flag;
					rdata_d[`B_RES_DONE] = p_q.resume_done_flag;
					rdata_d[`B_EN_CHG] = p_q.enable_change_flag;
					rdata_d[`B_ATT_CHG] = p_q.attach_change_flag;
					rdata_d[`B_SLOW] = p_q.slow_device_flag;
					rdata_d[`B_POWER] = p_q.port_powered;
					rdata_d[`B_RESET] = p_q.reset_active;
					rdata_d[`B_OVL] = p_q.overload_seen;
					rdata_d[`B_SUSP] = p_q.suspended_state;
					rdata_d[`B_ACTIVE] = p_q.link_active_state;
					rdata_d[`B_ATTACH] = p_q.attached_state;
				end
				`ADDR_CFG: begin
					rdata_d[4:0] = cfg_q;
				end
				default: begin
					rdata_d = 32'h0000_0000;
				end
			endcase
		end
		if (take && av_in.write && av_in.address == `ADDR_CFG && av_in.byteenable[0]) begin
			cfg_d = cfg_t'(av_in.writedata[4:0]);
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (srst_in) begin
			wait_q <= 1'b1;
			rdata_q <= 32'h0000_0000;
			cfg_q <= cfg_t'(`CFG_RST);
		end else begin
			wait_q <= wait_d;
			rdata_q <= rdata_d;
			cfg_q <= cfg_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// port state, flags and reset/resume sequencer

	seq_t seq_q, seq_d;
	logic [17:0] div_q, div_d;
	logic [8:0] cnt_q, cnt_d;
	logic boot_q, boot_d;
	logic rst_drv_q, rst_drv_d;
	logic res_drv_q, res_drv_d;
	logic tick;
	logic ovl;
	logic port_cmds;
	logic pwr_on;
	logic pwr_off;
	logic att_now;
	logic hw_drop;
	logic rst_end;
	logic res_end;

	// millisecond tick; divider held at zero while idle so every
	// interval is whole milliseconds long, never short
	assign tick = (div_q == MS_LAST);
	assign ovl = cfg_q.ovl_per_port_sel & pin_s2_q[2];
	// per-port commands only in per-port mode with the mask bit set
	assign port_cmds = cfg_q.per_port_switch_sel & cfg_q.individual_power_mask;
	assign pwr_on = port_cmds ? w1[`B_POWER] : gp[`B_ALL_ON];
	assign pwr_off = port_cmds ? w1[`B_SLOW] : gp[`B_ALL_OFF];

	always_comb begin
		p_d = p_q;
		seq_d = seq_q;
		cnt_d = cnt_q;
		// stays armed until a fixed device is declared, so the announce fires once
		boot_d = boot_q & ~cfg_q.fixed_device_mask;
		rst_end = 1'b0;
		res_end = 1'b0;
		div_d = (seq_q == SEQ_IDLE || tick) ? 18'h0_0000 : div_q + 18'h0_0001;

		// power: commands, then overcurrent wins over them
		if (pwr_off) begin
			p_d.port_powered = 1'b0;
		end
		if (pwr_on) begin
			p_d.port_powered = 1'b1;
		end
		if (ovl) begin
			p_d.port_powered = 1'b0;
		end
		if (cfg_q.no_power_switch) begin
			p_d.port_powered = 1'b1;
		end

		// an unpowered port sees no device unless it is fixed
		att_now = cfg_q.fixed_device_mask | (pin_s2_q[0] & p_d.port_powered);
		p_d.attached_state = att_now;
		p_d.slow_device_flag = pin_s2_q[1] & att_now;
		p_d.overload_seen = ovl;

		// write-one clears come first so a same-cycle set wins
		if (w1[`B_RST_DONE]) begin
			p_d.reset_done_flag = 1'b0;
		end
		if (w1[`B_OVL_CHG]) begin
			p_d.ovl_change_flag = 1'b0;
		end
		if (w1[`B_RES_DONE]) begin
			p_d.resume_done_flag = 1'b0;
		end
		if (w1[`B_EN_CHG]) begin
			p_d.enable_change_flag = 1'b0;
		end
		if (w1[`B_ATT_CHG]) begin
			p_d.attach_change_flag = 1'b0;
		end

		if (ovl != p_q.overload_seen) begin
			p_d.ovl_change_flag = 1'b1;
		end
		if (att_now != p_q.attached_state) begin
			p_d.attach_change_flag = 1'b1;
		end
		if (boot_q && cfg_q.fixed_device_mask) begin
			p_d.attach_change_flag = 1'b1;
		end
		if (!att_now && (w1[`B_RESET] || w1[`B_ACTIVE] || w1[`B_SUSP])) begin
			p_d.attach_change_flag = 1'b1;
		end

		// software enable and disable; no change flag for these
		if (w1[`B_ATTACH]) begin
			p_d.link_active_state = 1'b0;
		end
		if (w1[`B_ACTIVE] && att_now) begin
			p_d.link_active_state = 1'b1;
		end

		// suspend request and controller wake
		if (w1[`B_SUSP] && att_now) begin
			p_d.suspended_state = 1'b1;
		end
		if (controller_wake_state_in) begin
			p_d.suspended_state = 1'b0;
		end

		// start reset; it overrides a resume in flight
		if (w1[`B_RESET] && att_now && seq_q != SEQ_RESET) begin
			p_d.reset_active = 1'b1;
			seq_d = SEQ_RESET;
			cnt_d = 9'h000;
			div_d = 18'h0_0000;
		end else if (w1[`B_OVL] && p_q.suspended_state && seq_q == SEQ_IDLE) begin
			seq_d = SEQ_RESUME;
			cnt_d = 9'h000;
		end else begin
			case (seq_q)
				SEQ_IDLE: begin
					cnt_d = 9'h000;
				end
				SEQ_RESET: begin
					if (tick) begin
						cnt_d = cnt_q + 9'h001;
						if (cnt_q == RESET_LAST) begin
							rst_end = 1'b1;
							seq_d = SEQ_IDLE;
						end
					end
				end
				SEQ_RESUME: begin
					if (tick) begin
						cnt_d = cnt_q + 9'h001;
						if (cnt_q == RESUME_LAST) begin
							seq_d = SEQ_EOP;
							cnt_d = 9'h000;
						end
					end
				end
				SEQ_EOP: begin
					// eop is shorter than a millisecond: count clocks
					cnt_d = cnt_q + 9'h001;
					if (cnt_q == EOP_LAST) begin
						seq_d = SEQ_RESYNC;
						cnt_d = 9'h000;
						div_d = 18'h0_0000;
					end
				end
				SEQ_RESYNC: begin
					if (tick) begin
						cnt_d = cnt_q + 9'h001;
						if (cnt_q == RESYNC_LAST) begin
							res_end = 1'b1;
							seq_d = SEQ_IDLE;
						end
					end
				end
				default: begin
					seq_d = SEQ_IDLE;
				end
			endcase
		end

		// sequence completions
		if (rst_end) begin
			p_d.reset_done_flag = 1'b1;
			p_d.reset_active = 1'b0;
			p_d.resume_done_flag = 1'b0;
			p_d.suspended_state = 1'b0;
			p_d.link_active_state = 1'b1;
		end
		if (res_end) begin
			p_d.resume_done_flag = 1'b1;
			p_d.suspended_state = 1'b0;
			p_d.link_active_state = 1'b1;
		end

		// faults seen by hardware drop the port and flag it
		hw_drop = ovl | ~att_now | ~p_d.port_powered | bus_error_in;
		if (hw_drop && p_q.link_active_state) begin
			p_d.enable_change_flag = 1'b1;
		end
		if (hw_drop) begin
			p_d.link_active_state = 1'b0;
		end

		// a lost device, or lost power on a port without a fixed device, ends any sequence
		if (!att_now) begin
			p_d.suspended_state = 1'b0;
			p_d.reset_active = 1'b0;
			seq_d = SEQ_IDLE;
		end

		rst_drv_d = (seq_d == SEQ_RESET);
		res_drv_d = (seq_d == SEQ_RESUME);
	end

	always_ff @(posedge sys_clk_in) begin
		if (srst_in) begin
			p_q <= port_t'(`PORT_STATE_RST);
			seq_q <= SEQ_IDLE;
			div_q <= 18'h0_0000;
			cnt_q <= 9'h000;
			boot_q <= 1'b1;
			rst_drv_q <= 1'b0;
			res_drv_q <= 1'b0;
		end else begin
			p_q <= p_d;
			seq_q <= seq_d;
			div_q <= div_d;
			cnt_q <= cnt_d;
			boot_q <= boot_d;
			rst_drv_q <= rst_drv_d;
			res_drv_q <= res_drv_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs, all straight from flops

	assign av_readdata_out = rdata_q;
	assign av_waitrequest_out = wait_q;
	assign port_power_out = p_q.port_powered;
	assign port_active_out = p_q.link_active_state;
	assign reset_drive_out = rst_drv_q;
	assign resume_drive_out = res_drv_q;

endmodule

/* testbench/usb_dev_model.sv */
// far-side model: presence, speed and overcurrent pins of the attached device
// assumes the bench picks plug, speed and short; pins move only after clock edges
`timescale 1ns/1ns
module usb_dev_model #(
	parameter int LAG = 2
) (
	input wire logic sys_clk_in,
	input wire logic plug_in,
	input wire logic slow_in,
	input wire logic short_in,
	output logic attach_out,
	output logic slow_out,
	output logic ovl_out
);
	logic [LAG-1:0] plug_q = '0;
	logic junk_q = 1'b0;
	////////////////////////////////////////////////////////////////
	// insertion settles late, so the port never sees presence at once
	always_ff @(posedge sys_clk_in) begin
		plug_q <= {plug_q[LAG-2:0], plug_in};
		junk_q <= ~junk_q;
	end
	assign attach_out = plug_q[LAG-1];
	// an absent device leaves the speed line floating: shown as a toggling pattern
	assign slow_out = attach_out ? slow_in : junk_q;
	assign ovl_out = short_in;
endmodule

/* testbench/port_chk.sv */
// checker of the root hub port, watching the top-level ports only
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ns
module port_chk #(
	parameter int MS_CYCLES = 20
) (
	input wire logic sys_clk_in,
	input wire logic srst_in,
	input wire port_pkg::av_req_t av_in,
	input wire logic [31:0] av_readdata_out,
	input wire logic av_waitrequest_out,
	input wire logic dev_attach_in,
	input wire logic dev_slow_in,
	input wire logic overload_in,
	input wire logic bus_error_in,
	input wire logic controller_wake_state_in,
	input wire logic port_power_out,
	input wire logic port_active_out,
	input wire logic reset_drive_out,
	input wire logic resume_drive_out
);
	localparam int RST_LO = 10 * MS_CYCLES - 2;
	localparam int RST_HI = 10 * MS_CYCLES + 2;
	localparam int RSM_LO = 20 * MS_CYCLES - 2;
	localparam int RSM_HI = 20 * MS_CYCLES + 2;
	logic [4:0] cfg_q;
	logic [31:0] span_q;
	logic wr_ok;
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (srst_in);
	////////////////////////////////////////////////////////////////
	// config shadow: power and overcurrent readings depend on it
	assign wr_ok = av_in.write && !av_waitrequest_out && av_in.byteenable[0];
	always_ff @(posedge sys_clk_in) begin
		if (srst_in) begin
			cfg_q <= 5'h00;
		end else if (wr_ok && av_in.address == 2'h1) begin
			cfg_q <= av_in.writedata[4:0];
		end
	end
	// length of the current reset or resume drive
	always_ff @(posedge sys_clk_in) begin
		if (srst_in || !(reset_drive_out || resume_drive_out)) begin
			span_q <= 32'h0000_0000;
		end else begin
			span_q <= span_q + 32'h0000_0001;
		end
	end
	sequence link_ready;
		port_power_out && dev_attach_in && $past(dev_attach_in, 4);
	endsequence
	sequence wr_port;
		wr_ok && av_in.address == 2'h0;
	endsequence
	////////////////////////////////////////////////////////////////
	chk_wait_one_cycle: assert property ($fell(av_waitrequest_out) |=> av_waitrequest_out)
		else $error("waitrequest low too long");
	chk_reset_length: assert property ($fell(reset_drive_out) |-> span_q >= RST_LO && span_q <= RST_HI)
		else $error("reset drive length off");
	chk_resume_length: assert property ($fell(resume_drive_out) |-> span_q >= RSM_LO && span_q <= RSM_HI)
		else $error("resume drive length off");
	chk_reset_then_active: assert property ($fell(reset_drive_out) ##0 link_ready |-> ##[0:2] port_active_out)
		else $error("port not enabled after reset");
	chk_sw_activate: assert property (link_ready ##0 wr_port ##0 (av_in.writedata[1] && !av_in.writedata[0]) |-> ##[1:2] port_active_out)
		else $error("enable write ignored");
	chk_sw_deactivate: assert property (wr_port ##0 av_in.writedata[0] |-> ##[1:2] !port_active_out)
		else $error("disable write ignored");
	chk_unpowered_idle: assert property (!port_power_out && $past(!port_power_out) |-> !port_active_out && !reset_drive_out && !resume_drive_out)
		else $error("activity without power");
	chk_overload_power: assert property ((cfg_q[2] && !cfg_q[0] && overload_in) [*4] |-> ##[0:3] !port_power_out)
		else $error("power kept on overload");
	chk_fixed_power: assert property (cfg_q[0] && $past(cfg_q[0]) |-> port_power_out)
		else $error("power off without switching");
	chk_babble_drop: assert property (bus_error_in |-> ##[1:2] !port_active_out)
		else $error("enable kept on bus error");
endmodule

bind usb_root_hub_port port_chk #(.MS_CYCLES(MS_CYCLES)) u_chk (
	.sys_clk_in(sys_clk_in), .srst_in(srst_in), .av_in(av_in),
	.av_readdata_out(av_readdata_out), .av_waitrequest_out(av_waitrequest_out),
	.dev_attach_in(dev_attach_in), .dev_slow_in(dev_slow_in), .overload_in(overload_in),
	.bus_error_in(bus_error_in), .controller_wake_state_in(controller_wake_state_in),
	.port_power_out(port_power_out), .port_active_out(port_active_out),
	.reset_drive_out(reset_drive_out), .resume_drive_out(resume_drive_out)
);

/* testbench/usb_root_hub_port_status_bench.sv */
// self-checking bench of the root hub port over its avalon slave
// assumes port_cfg.svh timing; the ms tick is shortened to MS cycles
`timescale 1ns/1ns
`include "port_cfg.svh"
module usb_root_hub_port_status_bench;
	localparam int MS = 20;
	localparam logic [31:0] F = 32'hFFFF_FFFF;
	localparam logic [31:0] NS = 32'hFFFF_FDFF;
	logic sys_clk_in, srst_in, bus_error_in, controller_wake_state_in;
	logic dev_plug, dev_slow_sel, dev_short, dev_attach_in, dev_slow_in, overload_in;
	port_pkg::av_req_t av_in;
	logic [31:0] av_readdata_out, rq;
	logic av_waitrequest_out, port_power_out, port_active_out, reset_drive_out, resume_drive_out;
	int mismatches, samples_checked;

	usb_root_hub_port #(.MS_CYCLES(MS)) DUT (
		.sys_clk_in(sys_clk_in), .srst_in(srst_in), .av_in(av_in),
		.av_readdata_out(av_readdata_out), .av_waitrequest_out(av_waitrequest_out),
		.dev_attach_in(dev_attach_in), .dev_slow_in(dev_slow_in), .overload_in(overload_in),
		.bus_error_in(bus_error_in), .controller_wake_state_in(controller_wake_state_in),
		.port_power_out(port_power_out), .port_active_out(port_active_out),
		.reset_drive_out(reset_drive_out), .resume_drive_out(resume_drive_out)
	);
	usb_dev_model dev (.sys_clk_in(sys_clk_in), .plug_in(dev_plug), .slow_in(dev_slow_sel),
		.short_in(dev_short), .attach_out(dev_attach_in), .slow_out(dev_slow_in),
		.ovl_out(overload_in));

	initial begin
		sys_clk_in = 1'b0;
		forever #2 sys_clk_in = ~sys_clk_in;
	end
	////////////////////////////////////////////////////////////////
	task automatic test_done;
		$display("compares %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// a wait that runs out ends the run as a failure
	task automatic bound(input int n, input int lim);
		if (n >= lim) begin
			mismatches++;
			$display("wrong value timeout expected %0d seen %0d", lim, n);
			test_done;
		end
	endtask
	// one avalon access: held until waitrequest is sampled low, then released
	task automatic acc(input logic wr, input logic [1:0] a, input logic [31:0] d);
		int n;
		av_in <= '{read: !wr, write: wr, address: a, byteenable: 4'hF, writedata: d};
		n = 0;
		do begin
			@(posedge sys_clk_in);
			n++;
		end while (av_waitrequest_out !== 1'b0 && n < 50);
		rq = av_readdata_out;
		av_in.read <= 1'b0;
		av_in.write <= 1'b0;
		bound(n, 50);
		@(posedge sys_clk_in);
	endtask
	task automatic wr(input logic [1:0] a, input logic [31:0] d);
		acc(1'b1, a, d);
	endtask
	task automatic rdc(input string nm, input logic [1:0] a, input logic [31:0] m,
		input logic [31:0] exp);
		acc(1'b0, a, 32'h0000_0000);
		check(nm, rq & m, exp);
	endtask
	// wait for the reset or resume drive to reach a level
	task automatic await(input logic rsm, input logic lvl);
		int n;
		n = 0;
		while (((rsm ? resume_drive_out : reset_drive_out) !== lvl) && n < 2000) begin
			@(posedge sys_clk_in);
			n++;
		end
		bound(n, 2000);
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		mismatches = 0;
		samples_checked = 0;
		srst_in = 1'b1;
		bus_error_in = 1'b0;
		controller_wake_state_in = 1'b0;
		av_in = '0;
		dev_plug = 1'b0;
		dev_slow_sel = 1'b1;
		dev_short = 1'b0;
		repeat (5) @(posedge sys_clk_in);
		srst_in <= 1'b0;
		@(posedge sys_clk_in);
		rdc("reset", 2'h0, NS, 32'h0000_0100);
		wr(2'h3, F);
		rdc("hole", 2'h3, F, 32'h0000_0000);
		rdc("gpwr", 2'h2, F, 32'h0000_0000);
		wr(2'h0, 32'h0000_0016);
		rdc("detached", 2'h0, NS, 32'h0001_0100);
		wr(2'h0, 32'h0000_0000);
		rdc("zero", 2'h0, NS, 32'h0001_0100);
		wr(2'h0, 32'h0001_0000);
		rdc("clr", 2'h0, NS, 32'h0000_0100);
		dev_plug <= 1'b1;
		repeat (8) @(posedge sys_clk_in);
		rdc("attach", 2'h0, F, 32'h0001_0301);
		wr(2'h0, 32'h0001_0010);
		rdc("rst on", 2'h0, F, 32'h0000_0311);
		await(1'b0, 1'b0);
		rdc("rst done", 2'h0, F, 32'h0010_0303);
		wr(2'h0, 32'h0010_0004);
		rdc("susp", 2'h0, F, 32'h0000_0307);
		wr(2'h0, 32'h0000_0008);
		await(1'b1, 1'b1);
		await(1'b1, 1'b0);
		rdc("early", 2'h0, 32'h0004_0004, 32'h0000_0004);
		repeat (`EOP_CYCLES + `RESYNC_MS * MS - 10) @(posedge sys_clk_in);
		rdc("resync", 2'h0, 32'h0004_0004, 32'h0000_0004);
		repeat (20) @(posedge sys_clk_in);
		rdc("rsm done", 2'h0, F, 32'h0004_0303);
		wr(2'h0, 32'h0000_0010);
		await(1'b0, 1'b1);
		await(1'b0, 1'b0);
		rdc("rst clr", 2'h0, F, 32'h0010_0303);
		wr(2'h0, 32'h0010_0004);
		controller_wake_state_in <= 1'b1;
		@(posedge sys_clk_in);
		controller_wake_state_in <= 1'b0;
		rdc("wake", 2'h0, 32'h0000_0004, 32'h0000_0000);
		bus_error_in <= 1'b1;
		@(posedge sys_clk_in);
		bus_error_in <= 1'b0;
		rdc("babble", 2'h0, F, 32'h0002_0301);
		wr(2'h0, 32'h0002_0002);
		rdc("sw on", 2'h0, F, 32'h0000_0303);
		wr(2'h0, 32'h0000_0001);
		rdc("sw off", 2'h0, F, 32'h0000_0301);
		wr(2'h0, 32'h0000_0002);
		wr(2'h1, 32'h0000_000A);
		wr(2'h0, 32'h0000_0200);
		rdc("pwr off", 2'h0, NS, 32'h0003_0000);
		wr(2'h2, 32'h0001_0000);
		rdc("masked", 2'h0, 32'h0000_0100, 32'h0000_0000);
		wr(2'h0, 32'h0000_0100);
		rdc("pwr on", 2'h0, 32'h0000_0100, 32'h0000_0100);
		wr(2'h0, 32'h0000_0200);
		wr(2'h1, 32'h0000_0001);
		rdc("no sw", 2'h0, 32'h0000_0100, 32'h0000_0100);
		wr(2'h1, 32'h0000_0000);
		wr(2'h2, 32'h0000_0001);
		rdc("all off", 2'h0, 32'h0000_0100, 32'h0000_0000);
		wr(2'h2, 32'h0001_0000);
		rdc("all on", 2'h0, 32'h0000_0100, 32'h0000_0100);
		dev_slow_sel <= 1'b0;
		repeat (8) @(posedge sys_clk_in);
		rdc("full", 2'h0, 32'h0000_0201, 32'h0000_0001);
		wr(2'h1, 32'h0000_0004);
		dev_short <= 1'b1;
		repeat (6) @(posedge sys_clk_in);
		rdc("ovl", 2'h0, 32'h0000_0108, 32'h0000_0008);
		dev_short <= 1'b0;
		repeat (6) @(posedge sys_clk_in);
		rdc("ovl gone", 2'h0, 32'h0000_0008, 32'h0000_0000);
		wr(2'h2, 32'h0001_0000);
		wr(2'h0, 32'h0001_0000);
		wr(2'h1, 32'h0000_0010);
		dev_plug <= 1'b0;
		repeat (8) @(posedge sys_clk_in);
		rdc("fixed", 2'h0, 32'h0001_0001, 32'h0001_0001);
		wr(2'h0, 32'h0001_0000);
		rdc("once", 2'h0, 32'h0001_0001, 32'h0000_0001);
		test_done;
	end
endmodule
